// ---- design/fcim_flow_credit_info_mux.sv ----
`timescale 1ns/1ns
`include "fcim_defs.svh"
module fcim_flow_credit_info_mux (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                link_up,
    input  wire logic [2:0]          credit_info_select,
    input  wire logic                rx_arrive_valid,
    input  wire logic [1:0]          rx_arrive_pool,
    input  wire logic [12:0]         rx_arrive_bytes,
    input  wire logic                rx_drain_valid,
    input  wire logic [1:0]          rx_drain_pool,
    input  wire logic [12:0]         rx_drain_bytes,
    input  wire logic                tx_write_valid,
    input  wire logic [1:0]          tx_write_pool,
    input  wire logic [12:0]         tx_write_bytes,
    input  wire logic [2:0]          tx_head_valid,
    input  wire fcim_pkg::fcim_len_t tx_head_bytes,
    input  wire logic                tx_posted_first,
    input  wire logic                fc_update_valid,
    input  wire logic [1:0]          fc_update_pool,
    input  wire logic [7:0]          fc_update_hdr,
    input  wire logic [11:0]         fc_update_data,
    input  wire fcim_pkg::fcim_cnt_t partner_init,
    input  wire logic [2:0]          partner_infinite,
    output logic [2:0]               tx_grant,
    output logic [7:0]               posted_header_credits,
    output logic [11:0]              posted_data_credits,
    output logic [7:0]               nonposted_header_credits,
    output logic [11:0]              nonposted_data_credits,
    output logic [7:0]               completion_header_credits,
    output logic [11:0]              completion_data_credits
);
    import fcim_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [11:0] units(input logic [12:0] bytes);
        logic [13:0] s;
        s = {1'b0, bytes} + `FCIM_UNIT_ROUND;
        return {2'h0, s[13:`FCIM_UNIT_SHIFT]};
    endfunction : units

    function automatic logic [11:0] wmask(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r[11:0];
    endfunction : wmask

    // Values aligned with sign at bit 11; header values arrive shifted up
    function automatic logic [11:0] view(input logic [2:0] sel, input logic [11:0] al, input logic [11:0] rc,
                                         input logic [11:0] li, input logic [11:0] co, input logic [11:0] qu,
                                         input logic ri, input logic pi);
        logic [11:0] d;
        d = 12'h000;
        unique case (sel)
            FCIM_RX_AVAIL: begin
                d = al - rc;
                if (d[`FCIM_SIGN_BIT]) begin
                    d = 12'h000;
                end
            end
            FCIM_RX_LIMIT: d = ri ? 12'h000 : {1'b0, al[10:0]};
            FCIM_RX_CONS:  d = {1'b0, rc[10:0]};
            FCIM_TX_AVAIL: d = pi ? `FCIM_INF_VAL : li - co - qu;
            FCIM_TX_LIMIT: d = pi ? 12'h000 : {1'b0, li[10:0]};
            FCIM_TX_CONS:  d = {1'b0, co[10:0]};
            default:       d = 12'h000;
        endcase
        return d;
    endfunction : view

    function automatic logic [11:0] up(input logic [11:0] v, input logic k);
        return k ? v : {v[7:0], 4'h0};
    endfunction : up

    ////////////////////////////////////////////////////////////////////////
    // State
    fcim_state_t q_r;
    fcim_state_t q_nxt;
    fcim_state_t rst_c;

    always_comb begin
        rst_c = '0;
        rst_c.rx_inf = `FCIM_RST_RX_INF;
        rst_c.rx_init[0][0] = `FCIM_RST_PH;
        rst_c.rx_init[0][1] = `FCIM_RST_PD;
        rst_c.rx_init[1][0] = `FCIM_RST_NPH;
        rst_c.rx_init[1][1] = `FCIM_RST_NPD;
        rst_c.rx_init[2][0] = `FCIM_RST_CPLH;
        rst_c.rx_init[2][1] = `FCIM_RST_CPLD;
    end

    logic [2:0]  fits;
    logic [2:0]  blocked;
    logic [2:0]  gnt;
    logic [11:0] need [3];
    logic [11:0] room;
    logic [11:0] hroom;
    logic [11:0] v;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        q_nxt = q_r;
        fits = 3'h0;
        gnt = 3'h0;
        room = 12'h000;
        hroom = 12'h000;
        v = 12'h000;
        for (int i = 0; i < 3; i++) begin
            need[i] = units(tx_head_bytes[i]);
            room = q_r.lim[i][1] - q_r.cons[i][1];
            hroom = {q_r.lim[i][0][7:0] - q_r.cons[i][0][7:0], 4'h0};
            fits[i] = q_r.pinf[i] | (!room[11] && room >= need[i] && !hroom[11] && hroom != 12'h000);
        end
        blocked = tx_head_valid & ~fits;

        // Transmit arbitration
        if (q_r.link && q_r.grant == 3'h0) begin
            if (tx_head_valid[0] && fits[0] && !(blocked[2] && !tx_posted_first)) begin
                gnt[0] = 1'b1;
            end
            if (tx_head_valid[2] && fits[2] && !(blocked[0] && tx_posted_first)) begin
                gnt[2] = 1'b1;
            end
            if (gnt[0] && gnt[2]) begin
                gnt = tx_posted_first ? 3'h1 : 3'h4;
            end
            if (gnt == 3'h0 && tx_head_valid[1] && fits[1]) begin
                gnt[1] = 1'b1;
            end
        end
        q_nxt.grant = gnt;

        // Credit counters
        q_nxt.link = link_up;
        if (!link_up) begin
            q_nxt.alloc = '0;
            q_nxt.recv = '0;
            q_nxt.lim = '0;
            q_nxt.cons = '0;
            q_nxt.queued = '0;
            q_nxt.pinf = 3'h0;
            q_nxt.grant = 3'h0;
        end else if (!q_r.link) begin
            q_nxt.alloc = q_r.rx_init;
            q_nxt.lim = partner_init;
            q_nxt.pinf = partner_infinite;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (rx_arrive_valid && rx_arrive_pool == 2'(i)) begin
                    q_nxt.recv[i][0] = q_nxt.recv[i][0] + 12'h001;
                    q_nxt.recv[i][1] = q_nxt.recv[i][1] + units(rx_arrive_bytes);
                end
                if (rx_drain_valid && rx_drain_pool == 2'(i)) begin
                    q_nxt.alloc[i][0] = q_nxt.alloc[i][0] + 12'h001;
                    q_nxt.alloc[i][1] = q_nxt.alloc[i][1] + units(rx_drain_bytes);
                end
                if (fc_update_valid && fc_update_pool == 2'(i)) begin
                    q_nxt.lim[i][0] = q_nxt.lim[i][0] + {4'h0, fc_update_hdr};
                    q_nxt.lim[i][1] = q_nxt.lim[i][1] + fc_update_data;
                end
                if (tx_write_valid && tx_write_pool == 2'(i)) begin
                    q_nxt.queued[i][0] = q_nxt.queued[i][0] + 12'h001;
                    q_nxt.queued[i][1] = q_nxt.queued[i][1] + units(tx_write_bytes);
                end
                if (gnt[i]) begin
                    q_nxt.queued[i][0] = q_nxt.queued[i][0] - 12'h001;
                    q_nxt.queued[i][1] = q_nxt.queued[i][1] - need[i];
                    q_nxt.cons[i][0] = q_nxt.cons[i][0] + 12'h001;
                    q_nxt.cons[i][1] = q_nxt.cons[i][1] + need[i];
                end
            end
        end

        // Selector pipeline: stage one holds the code, stage two the views
        q_nxt.sel = credit_info_select;
        for (int i = 0; i < 3; i++) begin
            for (int k = 0; k < 2; k++) begin
                v = view(q_r.sel, up(q_r.alloc[i][k], k[0]), up(q_r.recv[i][k], k[0]),
                         up(q_r.lim[i][k], k[0]), up(q_r.cons[i][k], k[0]),
                         up(q_r.queued[i][k], k[0]), q_r.rx_inf[i], q_r.pinf[i]);
                if (k == 0) begin
                    v = {4'h0, v[11:4]};
                end
                q_nxt.outv[i][k] = q_r.link ? v : 12'h000;
            end
        end

        // AXI write
        if (s_axi_awvalid && q_r.awready) begin
            q_nxt.aw_have = 1'b1;
            q_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q_r.wready) begin
            q_nxt.w_have = 1'b1;
            q_nxt.wdata = s_axi_wdata;
            q_nxt.wstrb = s_axi_wstrb;
        end
        if (q_r.bvalid && s_axi_bready) begin
            q_nxt.bvalid = 1'b0;
        end
        if (q_r.aw_have && q_r.w_have && !q_r.bvalid) begin
            q_nxt.aw_have = 1'b0;
            q_nxt.w_have = 1'b0;
            q_nxt.bvalid = 1'b1;
            q_nxt.bresp = `FCIM_RESP_OKAY;
            unique case (q_r.awaddr)
                `FCIM_OFF_RX_INF: begin
                    v = wmask({29'h0, q_r.rx_inf}, q_r.wdata, q_r.wstrb);
                    q_nxt.rx_inf = v[2:0];
                end
                `FCIM_OFF_RX_INIT_H: begin
                    for (int b = 0; b < 3; b++) begin
                        if (q_r.wstrb[b]) begin
                            q_nxt.rx_init[b][0] = {4'h0, q_r.wdata[b*8 +: 8]};
                        end
                    end
                end
                `FCIM_OFF_RX_INIT_PD: q_nxt.rx_init[0][1] = wmask({20'h0, q_r.rx_init[0][1]}, q_r.wdata, q_r.wstrb);
                `FCIM_OFF_RX_INIT_ND: q_nxt.rx_init[1][1] = wmask({20'h0, q_r.rx_init[1][1]}, q_r.wdata, q_r.wstrb);
                `FCIM_OFF_RX_INIT_CD: q_nxt.rx_init[2][1] = wmask({20'h0, q_r.rx_init[2][1]}, q_r.wdata, q_r.wstrb);
                `FCIM_OFF_STATUS: q_nxt.bresp = `FCIM_RESP_OKAY;
                default: q_nxt.bresp = `FCIM_RESP_SLVERR;
            endcase
        end
        q_nxt.awready = !q_nxt.aw_have && !q_nxt.bvalid;
        q_nxt.wready = !q_nxt.w_have && !q_nxt.bvalid;

        // AXI read
        if (q_r.rvalid && s_axi_rready) begin
            q_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q_r.arready) begin
            q_nxt.rvalid = 1'b1;
            q_nxt.rresp = `FCIM_RESP_OKAY;
            unique case (s_axi_araddr)
                `FCIM_OFF_RX_INF:     q_nxt.rdata = {29'h0, q_r.rx_inf};
                `FCIM_OFF_RX_INIT_H:  q_nxt.rdata = {8'h00, q_r.rx_init[2][0][7:0], q_r.rx_init[1][0][7:0],
                                                     q_r.rx_init[0][0][7:0]};
                `FCIM_OFF_RX_INIT_PD: q_nxt.rdata = {20'h0, q_r.rx_init[0][1]};
                `FCIM_OFF_RX_INIT_ND: q_nxt.rdata = {20'h0, q_r.rx_init[1][1]};
                `FCIM_OFF_RX_INIT_CD: q_nxt.rdata = {20'h0, q_r.rx_init[2][1]};
                `FCIM_OFF_STATUS:     q_nxt.rdata = {25'h0, q_r.pinf, blocked, q_r.link};
                default: begin
                    q_nxt.rdata = 32'h0000_0000;
                    q_nxt.rresp = `FCIM_RESP_SLVERR;
                end
            endcase
        end
        q_nxt.arready = !q_nxt.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_r <= rst_c;
        end else begin
            q_r <= q_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign s_axi_awready = q_r.awready;
    assign s_axi_wready = q_r.wready;
    assign s_axi_bresp = q_r.bresp;
    assign s_axi_bvalid = q_r.bvalid;
    assign s_axi_arready = q_r.arready;
    assign s_axi_rdata = q_r.rdata;
    assign s_axi_rresp = q_r.rresp;
    assign s_axi_rvalid = q_r.rvalid;
    assign tx_grant = q_r.grant;
    assign posted_header_credits = q_r.outv[0][0][7:0];
    assign posted_data_credits = q_r.outv[0][1];
    assign nonposted_header_credits = q_r.outv[1][0][7:0];
    assign nonposted_data_credits = q_r.outv[1][1];
    assign completion_header_credits = q_r.outv[2][0][7:0];
    assign completion_data_credits = q_r.outv[2][1];
endmodule : fcim_flow_credit_info_mux

// ---- design/fcim_defs.svh ----
`ifndef FCIM_DEFS_SVH
`define FCIM_DEFS_SVH
`define FCIM_OFF_RX_INF     8'h00
`define FCIM_OFF_RX_INIT_H  8'h04
`define FCIM_OFF_RX_INIT_PD 8'h08
`define FCIM_OFF_RX_INIT_ND 8'h0C
`define FCIM_OFF_RX_INIT_CD 8'h10
`define FCIM_OFF_STATUS     8'h14
`define FCIM_RST_RX_INF     3'h4
`define FCIM_RST_PH         12'h020
`define FCIM_RST_NPH        12'h00C
`define FCIM_RST_CPLH       12'h024
`define FCIM_RST_PD         12'h09A
`define FCIM_RST_NPD        12'h00C
`define FCIM_RST_CPLD       12'h09A
`define FCIM_INF_VAL        12'h7FF
`define FCIM_SIGN_BIT       11
`define FCIM_UNIT_ROUND     14'h000F
`define FCIM_UNIT_SHIFT     4
`define FCIM_RESP_OKAY      2'h0
`define FCIM_RESP_SLVERR    2'h2
`endif

// ---- design/fcim_pkg.sv ----
package fcim_pkg;
    typedef enum logic [2:0] {
        FCIM_RX_AVAIL = 3'h0,
        FCIM_RX_LIMIT = 3'h1,
        FCIM_RX_CONS  = 3'h2,
        FCIM_RSV_3    = 3'h3,
        FCIM_TX_AVAIL = 3'h4,
        FCIM_TX_LIMIT = 3'h5,
        FCIM_TX_CONS  = 3'h6,
        FCIM_RSV_7    = 3'h7
    } fcim_sel_t;

    typedef logic [2:0][1:0][11:0] fcim_cnt_t;
    typedef logic [2:0][12:0]      fcim_len_t;

    typedef struct packed {
        logic [2:0]  sel;
        logic        link;
        fcim_cnt_t   alloc;
        fcim_cnt_t   recv;
        fcim_cnt_t   lim;
        fcim_cnt_t   cons;
        fcim_cnt_t   queued;
        fcim_cnt_t   outv;
        logic [2:0]  pinf;
        logic [2:0]  grant;
        logic [2:0]  rx_inf;
        fcim_cnt_t   rx_init;
        logic        aw_have;
        logic        w_have;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } fcim_state_t;
endpackage : fcim_pkg

// ---- sim/fcim_props.sv ----
`timescale 1ns/1ns
module fcim_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        link_up,
    input wire logic [2:0]  credit_info_select,
    input wire logic [2:0]  partner_infinite,
    input wire logic [2:0]  tx_head_valid,
    input wire logic [2:0]  tx_grant,
    input wire logic        rx_arrive_valid,
    input wire logic [7:0]  posted_header_credits,
    input wire logic [11:0] posted_data_credits,
    input wire logic [7:0]  nonposted_header_credits,
    input wire logic [11:0] nonposted_data_credits,
    input wire logic [7:0]  completion_header_credits,
    input wire logic [11:0] completion_data_credits
);
    logic [2:0] inf_r;
    logic       link_r;
    logic       zero_w;
    logic       msb_w;
    logic       cmax_w;
    logic       czero_w;
    assign zero_w = {posted_header_credits, posted_data_credits, nonposted_header_credits,
                     nonposted_data_credits, completion_header_credits, completion_data_credits} == 60'h0;
    assign msb_w = posted_header_credits[7] | posted_data_credits[11] | nonposted_header_credits[7] |
                   nonposted_data_credits[11] | completion_header_credits[7] | completion_data_credits[11];
    assign cmax_w = completion_header_credits == 8'h7F && completion_data_credits == 12'h7FF;
    assign czero_w = completion_header_credits == 8'h00 && completion_data_credits == 12'h000;
    ////////////////////////////////////////////////////////////////////////////////
    // Partner infinite flags as captured at link-up
    always_ff @(posedge aclk) begin
        link_r <= aresetn && link_up;
        if (aresetn && link_up && !link_r) begin
            inf_r <= partner_infinite;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reserved_zero_a: assert property (credit_info_select[1:0] == 2'h3 |-> ##2 zero_w)
        else $error("reserved view not zero");
    link_down_zero_a: assert property (!link_up |-> ##2 zero_w)
        else $error("credits not zero with link down");
    msb_clear_a: assert property (credit_info_select != 3'h4 |-> ##2 !msb_w)
        else $error("negative value outside transmit available view");
    tx_inf_max_a: assert property (credit_info_select == 3'h4 && link_up |-> ##2 (!inf_r[2] || cmax_w))
        else $error("infinite pool not at maximum");
    tx_inf_limit_a: assert property (credit_info_select == 3'h5 && link_up |-> ##2 (!inf_r[2] || czero_w))
        else $error("infinite pool limit not zero");
    grant_head_a: assert property (|tx_grant |-> (tx_grant & ~$past(tx_head_valid)) == 3'h0)
        else $error("grant without waiting head");
    grant_pulse_a: assert property (|tx_grant |-> $onehot(tx_grant) ##1 tx_grant == 3'h0)
        else $error("grant not a single one-hot pulse");
    rx_cons_steady_a: assert property ((credit_info_select == 3'h2 && link_up && !rx_arrive_valid)[*3]
        |=> $stable(posted_header_credits) && $stable(posted_data_credits))
        else $error("consumed view moved without arrival");
    grant_c: cover property (|tx_grant);
    link_c: cover property ($rose(link_up));
    negative_c: cover property (credit_info_select == 3'h4 && msb_w);
endmodule : fcim_props

bind fcim_flow_credit_info_mux fcim_props u_props (
    .aclk, .aresetn, .link_up, .credit_info_select, .partner_infinite, .tx_head_valid, .tx_grant,
    .rx_arrive_valid, .posted_header_credits, .posted_data_credits, .nonposted_header_credits,
    .nonposted_data_credits, .completion_header_credits, .completion_data_credits
);

// ---- sim/fcim_user_model.sv ----
`timescale 1ns/1ns
module fcim_user_model (
    input  wire logic           aclk,
    input  wire logic           aresetn,
    input  wire logic           req_valid,
    input  wire logic [1:0]     req_pool,
    input  wire logic [12:0]    req_bytes,
    input  wire logic [2:0]     tx_grant,
    output logic                tx_write_valid,
    output logic [1:0]          tx_write_pool,
    output logic [12:0]         tx_write_bytes,
    output logic [2:0]          tx_head_valid,
    output fcim_pkg::fcim_len_t tx_head_bytes,
    output logic                tx_posted_first
);
    import fcim_pkg::*;
    logic [2:0][3:0] pend_r;
    // Queue heads: a pool waits while it holds unsent packets
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            tx_head_valid[i] = pend_r[i] != 4'h0;
        end
    end
    always_ff @(posedge aclk) begin
        tx_write_valid <= aresetn && req_valid;
        tx_write_pool <= req_pool;
        tx_write_bytes <= req_valid ? req_bytes : ~tx_write_bytes;
        for (int i = 0; i < 3; i++) begin
            pend_r[i] <= pend_r[i] + 4'(req_valid && req_pool == 2'(i)) - 4'(tx_grant[i]);
            if (req_valid && req_pool == 2'(i)) begin
                tx_head_bytes[i] <= req_bytes;
            end else if (pend_r[i] == 4'h0) begin
                tx_head_bytes[i] <= ~tx_head_bytes[i];
            end
        end
        // Age of posted head against completion head
        if (req_valid && req_pool == 2'h0 && pend_r[2] == 4'h0) begin
            tx_posted_first <= 1'b1;
        end else if (req_valid && req_pool == 2'h2 && pend_r[0] == 4'h0) begin
            tx_posted_first <= 1'b0;
        end
        if (!aresetn) begin
            pend_r <= '0;
            tx_head_bytes <= '0;
            tx_posted_first <= 1'b0;
        end
    end
endmodule : fcim_user_model

// ---- sim/fcim_flow_credit_info_mux_test.sv ----
`timescale 1ns/1ns
module fcim_flow_credit_info_mux_test;
    import fcim_pkg::*;
    localparam logic [11:0] Z = 12'h000;
    logic        aclk, aresetn, link_up, req_valid, rx_arrive_valid, rx_drain_valid, tx_write_valid;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tx_posted_first, fc_update_valid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, fc_update_hdr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rx_arrive_pool, rx_drain_pool, tx_write_pool, fc_update_pool, req_pool;
    logic [2:0]  credit_info_select, tx_head_valid, tx_grant, partner_infinite;
    logic [12:0] rx_arrive_bytes, rx_drain_bytes, tx_write_bytes, req_bytes;
    logic [11:0] fc_update_data;
    logic [7:0]  posted_header_credits, nonposted_header_credits, completion_header_credits;
    logic [11:0] posted_data_credits, nonposted_data_credits, completion_data_credits;
    fcim_len_t   tx_head_bytes;
    fcim_cnt_t   partner_init;
    int          n_mismatch, n_checks;
    fcim_flow_credit_info_mux u_dut (.*);
    fcim_user_model u_user (.*);
    always #2 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("mismatches %0d checks %0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        s_axi_bready <= 1'b0;
        chk("bvalid", 32'h1, 32'(s_axi_bvalid));
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        s_axi_rready <= 1'b0;
        chk("rvalid", 32'h1, 32'(s_axi_rvalid));
        chk("rresp", 32'(er), 32'(s_axi_rresp));
        chk("rdata", ed, s_axi_rdata);
    endtask : axi_rd
    task automatic view(input logic [2:0] s, input logic [11:0] ph, pd, nh, nd, ch, cd);
        credit_info_select <= s;
        repeat (2) @(posedge aclk);
        #1;
        chk("posted_header", 32'(ph), 32'(posted_header_credits));
        chk("posted_data", 32'(pd), 32'(posted_data_credits));
        chk("nonposted_header", 32'(nh), 32'(nonposted_header_credits));
        chk("nonposted_data", 32'(nd), 32'(nonposted_data_credits));
        chk("completion_header", 32'(ch), 32'(completion_header_credits));
        chk("completion_data", 32'(cd), 32'(completion_data_credits));
        @(posedge aclk);
    endtask : view
    task automatic pulse(input int k, input logic [1:0] p, input logic [12:0] b, input logic [11:0] d);
        rx_arrive_valid <= k == 0;
        rx_drain_valid <= k == 1;
        fc_update_valid <= k == 2;
        req_valid <= k == 3;
        {rx_arrive_bytes, rx_drain_bytes, req_bytes} <= {3{b}};
        {rx_arrive_pool, rx_drain_pool, fc_update_pool, req_pool} <= {4{p}};
        fc_update_hdr <= b[7:0];
        fc_update_data <= d;
        @(posedge aclk);
        {rx_arrive_valid, rx_drain_valid, fc_update_valid, req_valid} <= 4'h0;
    endtask : pulse
    task automatic wait_grant(input int i);
        int n;
        n = 0;
        while (tx_grant[i] !== 1'b1 && n < 40) begin
            @(posedge aclk);
            n++;
        end
        chk("tx_grant", 32'h1, 32'(tx_grant[i]));
    endtask : wait_grant
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {aclk, aresetn, link_up, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 8'h00;
        {req_valid, rx_arrive_valid, rx_drain_valid, fc_update_valid} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fc_update_hdr, fc_update_data} = 68'h0;
        {rx_arrive_pool, rx_drain_pool, fc_update_pool, req_pool, credit_info_select} = 11'h000;
        {rx_arrive_bytes, rx_drain_bytes, req_bytes} = 39'h0;
        s_axi_wstrb = 4'hF;
        partner_infinite = 3'h4;
        partner_init = '0;
        partner_init[0] = {12'h040, 12'h008};
        partner_init[1] = {12'h020, 12'h004};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axi_rd(8'h00, 32'h4, 2'h0);
        axi_rd(8'h04, 32'h00240C20, 2'h0);
        axi_wr(8'h0C, 32'h10, 2'h0);
        axi_rd(8'h0C, 32'h10, 2'h0);
        axi_wr(8'h20, 32'h1, 2'h2);
        axi_rd(8'h20, 32'h0, 2'h2);
        view(3'h4, Z, Z, Z, Z, Z, Z);
        link_up <= 1'b1;
        view(3'h0, 12'h020, 12'h09A, 12'h00C, 12'h010, 12'h024, 12'h09A);
        view(3'h1, 12'h020, 12'h09A, 12'h00C, 12'h010, Z, Z);
        view(3'h4, 12'h008, 12'h040, 12'h004, 12'h020, 12'h07F, 12'h7FF);
        view(3'h5, 12'h008, 12'h040, 12'h004, 12'h020, Z, Z);
        for (int s = 2; s < 8; s++) begin
            if (s inside {2, 3, 6, 7}) view(3'(s), Z, Z, Z, Z, Z, Z);
        end
        pulse(0, 2'h0, 13'h0021, Z);
        view(3'h2, 12'h001, 12'h003, Z, Z, Z, Z);
        view(3'h0, 12'h01F, 12'h097, 12'h00C, 12'h010, 12'h024, 12'h09A);
        pulse(1, 2'h0, 13'h0021, Z);
        view(3'h1, 12'h021, 12'h09D, 12'h00C, 12'h010, Z, Z);
        view(3'h0, 12'h020, 12'h09A, 12'h00C, 12'h010, 12'h024, 12'h09A);
        pulse(3, 2'h1, 13'h0258, Z);
        repeat (4) @(posedge aclk);
        axi_rd(8'h14, 32'h45, 2'h0);
        view(3'h4, 12'h008, 12'h040, 12'h003, 12'hFFA, 12'h07F, 12'h7FF);
        pulse(3, 2'h0, 13'h0040, Z);
        wait_grant(0);
        view(3'h6, 12'h001, 12'h004, Z, Z, Z, Z);
        view(3'h4, 12'h007, 12'h03C, 12'h003, 12'hFFA, 12'h07F, 12'h7FF);
        pulse(2, 2'h0, 13'h0001, 12'h004);
        view(3'h5, 12'h009, 12'h044, 12'h004, 12'h020, Z, Z);
        view(3'h4, 12'h008, 12'h040, 12'h003, 12'hFFA, 12'h07F, 12'h7FF);
        pulse(2, 2'h1, 13'h0000, 12'h006);
        wait_grant(1);
        view(3'h6, 12'h001, 12'h004, 12'h001, 12'h026, Z, Z);
        link_up <= 1'b0;
        view(3'h1, Z, Z, Z, Z, Z, Z);
        complete_run();
    end
    initial begin
        #20000;
        n_mismatch++;
        complete_run();
    end
endmodule : fcim_flow_credit_info_mux_test
